// *** common/awuh_pkg.sv ***
// Shared constants and types of the auto wake-up from halt timer.
// Assumes a 20 MHz system clock and an APB slave with 32-bit data.
package awuh_pkg;
   // ---------------------------------------------------------------
   // Register indices and byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] PRESC_INDEX = 8'h49;
   localparam logic [7:0] CSR_INDEX = 8'h4A;
   localparam logic [7:0] IRQ_STATUS_INDEX = 8'h4B;
   localparam logic [7:0] IRQ_MASK_INDEX = 8'h4C;
   localparam logic [11:0] PRESC_ADDR = {2'h0, PRESC_INDEX, 2'h0};
   localparam logic [11:0] CSR_ADDR = {2'h0, CSR_INDEX, 2'h0};
   localparam logic [11:0] IRQ_STATUS_ADDR = {2'h0, IRQ_STATUS_INDEX, 2'h0};
   localparam logic [11:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_INDEX, 2'h0};

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int CSR_ENABLE_BIT = 0;
   localparam int CSR_MEASURE_BIT = 1;
   localparam int CSR_FLAG_BIT = 2;
   localparam int IRQ_WAKE_BIT = 0;
   localparam int IRQ_EXIT_BIT = 1;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] PRESC_RESET = 8'hFF;
   localparam logic [7:0] PRESC_FORBIDDEN = 8'h00;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   localparam logic [1:0] IRQ_STATUS_RESET = 2'h0;

   // ---------------------------------------------------------------
   // Timing counts
   // ---------------------------------------------------------------
   localparam int FIX_DIV = 64;
   localparam logic [5:0] FIX_DIV_LAST = 6'(FIX_DIV - 1);
   localparam int STAB_SHORT_CYCLES = 256;
   localparam int STAB_LONG_CYCLES = 4096;
   localparam logic [11:0] STAB_SHORT_LAST = 12'(STAB_SHORT_CYCLES - 1);
   localparam logic [11:0] STAB_LONG_LAST = 12'(STAB_LONG_CYCLES - 1);

   // ---------------------------------------------------------------
   // Power state machine
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RUN = 3'h0,
      ST_RC_START = 3'h1,
      ST_COUNT = 3'h2,
      ST_HALT = 3'h3,
      ST_STAB = 3'h4
   } awuh_state_t;
endpackage

// *** hw/awuh_divider.sv ***
// Wake delay divider: fixed divide-by-64 followed by an 8-bit prescaler.
// Assumes tick is a one-cycle pulse per rising RC clock edge, already synchronised,
// and that presc is never zero (the register refuses zero).
module awuh_divider (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic clear,
   input wire logic run,
   input wire logic tick,
   input wire logic [7:0] presc,
   output logic expired
);
   logic [5:0] fix_cnt;
   logic [7:0] pre_cnt;

   // ---------------------------------------------------------------
   // Terminal decode
   // ---------------------------------------------------------------
   wire fix_wrap = (fix_cnt == awuh_pkg::FIX_DIV_LAST);
   wire [7:0] pre_last = 8'(presc - 8'h01);
   wire pre_wrap = (pre_cnt == pre_last);
   wire step = run && tick;

   // Counters; clear wins so each halt entry starts from zero
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fix_cnt <= 6'h0;
         pre_cnt <= 8'h00;
         expired <= 1'b0;
      end else if (clk_en) begin
         expired <= step && fix_wrap && pre_wrap;
         if (clear) begin
            fix_cnt <= 6'h0;
            pre_cnt <= 8'h00;
         end else if (step) begin
            fix_cnt <= fix_wrap ? 6'h0 : 6'(fix_cnt + 6'h1);
            if (fix_wrap) begin
               pre_cnt <= pre_wrap ? 8'h00 : 8'(pre_cnt + 8'h01);
            end
         end
      end
   end
endmodule

// *** hw/awuh_top.sv ***
// Auto wake-up from halt timer: APB registers, power sequencing, divider.
// Assumes halt_instr and halt_exit_irq come from logic on sys_clk, while
// rc_clk and rc_osc_ready come from the RC oscillator and are synchronised.
module awuh_top (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic halt_instr,
   input wire logic watchdog_enabled,
   input wire logic watchdog_halt_option,
   input wire logic stab_long_sel,
   input wire logic halt_exit_irq,
   input wire logic rc_clk,
   input wire logic rc_osc_ready,
   output logic rc_osc_enable,
   output logic rc_capture_clk,
   output logic main_osc_enable,
   output logic periph_clk_enable,
   output logic cpu_hold,
   output logic int_mask_clear,
   output logic wake_irq_req,
   output logic watchdog_reset_req,
   output logic auto_wake_halt_mode,
   output logic irq
);
   awuh_pkg::awuh_state_t state;
   awuh_pkg::awuh_state_t next_state;
   logic wake_enable;
   logic osc_measure_enable;
   logic wake_flag;
   logic [7:0] wake_prescaler_value;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic [11:0] stab_cnt;
   logic [1:0] sync_s1;
   logic [1:0] sync_s2;
   logic rc_prev;
   logic expired;

   // ---------------------------------------------------------------
   // Synchronisers for the RC domain signals
   // ---------------------------------------------------------------
   // Two stages each; only the second stage feeds any logic
   wire [1:0] async_in = {rc_osc_ready, rc_clk};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               sync_s1[gi] <= 1'b0;
               sync_s2[gi] <= 1'b0;
            end else if (clk_en) begin
               sync_s1[gi] <= async_in[gi];
               sync_s2[gi] <= sync_s1[gi];
            end
         end
      end
   endgenerate

   // Edge history of the synchronised RC clock
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rc_prev <= 1'b0;
      end else if (clk_en) begin
         rc_prev <= sync_s2[0];
      end
   end

   wire rc_s = sync_s2[0];
   wire rc_ready_s = sync_s2[1];
   // RC must run below sys_clk/4 or edges are lost in the crossing
   wire rc_tick = rc_s && !rc_prev;

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] reg_addr);
      addr_hit = (addr == reg_addr);
   endfunction

   wire hit_presc = addr_hit(paddr, awuh_pkg::PRESC_ADDR);
   wire hit_csr = addr_hit(paddr, awuh_pkg::CSR_ADDR);
   wire hit_status = addr_hit(paddr, awuh_pkg::IRQ_STATUS_ADDR);
   wire hit_mask = addr_hit(paddr, awuh_pkg::IRQ_MASK_ADDR);
   wire hit_any = hit_presc || hit_csr || hit_status || hit_mask;
   wire apb_setup = psel && !penable;
   wire apb_done = psel && penable && pready;
   wire wr_ok = apb_done && pwrite && !pslverr;
   wire rd_csr_done = apb_done && !pwrite && hit_csr;

   // Read data; reserved bits of the control/status register are zero
   wire [7:0] csr_word = {5'h00, wake_flag, osc_measure_enable, wake_enable};
   wire [31:0] rd_word =
      hit_csr ? {24'h00_0000, csr_word} :
      hit_presc ? {24'h00_0000, wake_prescaler_value} :
      hit_status ? {30'h0000_0000, irq_status} :
      hit_mask ? {30'h0000_0000, irq_mask} : 32'h0000_0000;

   // Setup cycle latches the answer, so every access has no wait state
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= apb_setup;
         if (apb_setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr <= !hit_any;
         end
      end
   end

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_enable <= awuh_pkg::CSR_RESET[awuh_pkg::CSR_ENABLE_BIT];
         osc_measure_enable <= awuh_pkg::CSR_RESET[awuh_pkg::CSR_MEASURE_BIT];
         wake_prescaler_value <= awuh_pkg::PRESC_RESET;
         irq_mask <= awuh_pkg::IRQ_MASK_RESET;
      end else if (clk_en) begin
         if (wr_ok && hit_csr) begin
            wake_enable <= pwdata[awuh_pkg::CSR_ENABLE_BIT];
            osc_measure_enable <= pwdata[awuh_pkg::CSR_MEASURE_BIT];
         end
         if (wr_ok && hit_presc && pwdata[7:0] != awuh_pkg::PRESC_FORBIDDEN) begin
            wake_prescaler_value <= pwdata[7:0];
         end
         if (wr_ok && hit_mask) begin
            irq_mask <= pwdata[1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Wake flag and sticky interrupt status
   // ---------------------------------------------------------------
   // Only a flag that the read actually returned is cleared; a set wins
   wire flag_clear = rd_csr_done && prdata[awuh_pkg::CSR_FLAG_BIT];
   wire in_halt = (state == awuh_pkg::ST_RC_START) || (state == awuh_pkg::ST_COUNT) ||
                  (state == awuh_pkg::ST_HALT);
   wire [1:0] irq_set = {in_halt && halt_exit_irq, expired};
   wire [1:0] irq_clr = (wr_ok && hit_status) ? pwdata[1:0] : 2'h0;
   wire [1:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_flag <= awuh_pkg::CSR_RESET[awuh_pkg::CSR_FLAG_BIT];
         irq_status <= awuh_pkg::IRQ_STATUS_RESET;
         irq <= 1'b0;
      end else if (clk_en) begin
         // Write to the flag position has no path here
         wake_flag <= expired || (wake_flag && !flag_clear);
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & irq_mask);
      end
   end

   assign wake_irq_req = wake_flag;

   // ---------------------------------------------------------------
   // Power state machine
   // ---------------------------------------------------------------
   wire halt_take = halt_instr && (state == awuh_pkg::ST_RUN);
   wire wdg_trap = watchdog_enabled && !watchdog_halt_option;
   wire halt_enter = halt_take && !wdg_trap;
   wire [11:0] stab_last = stab_long_sel ? awuh_pkg::STAB_LONG_LAST :
                           awuh_pkg::STAB_SHORT_LAST;
   wire stab_done = (stab_cnt == stab_last);

   always_comb begin
      next_state = state;
      unique case (state)
         awuh_pkg::ST_RUN: begin
            if (halt_enter && wake_enable) begin
               next_state = awuh_pkg::ST_RC_START;
            end else if (halt_enter) begin
               next_state = awuh_pkg::ST_HALT;
            end
         end
         awuh_pkg::ST_RC_START: begin
            // Delay only starts once the RC oscillator reports it runs
            if (halt_exit_irq) begin
               next_state = awuh_pkg::ST_STAB;
            end else if (rc_ready_s) begin
               next_state = awuh_pkg::ST_COUNT;
            end
         end
         awuh_pkg::ST_COUNT: begin
            if (expired || halt_exit_irq) begin
               next_state = awuh_pkg::ST_STAB;
            end
         end
         awuh_pkg::ST_HALT: begin
            if (halt_exit_irq) begin
               next_state = awuh_pkg::ST_STAB;
            end
         end
         awuh_pkg::ST_STAB: begin
            if (stab_done) begin
               next_state = awuh_pkg::ST_RUN;
            end
         end
         default: begin
            next_state = awuh_pkg::ST_RUN;
         end
      endcase
   end

   // State and stabilisation counter
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= awuh_pkg::ST_RUN;
         stab_cnt <= 12'h000;
      end else if (clk_en) begin
         state <= next_state;
         stab_cnt <= (state == awuh_pkg::ST_STAB) ? 12'(stab_cnt + 12'h001) : 12'h000;
      end
   end

   // ---------------------------------------------------------------
   // Delay divider
   // ---------------------------------------------------------------
   awuh_divider u_divider (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .clear(state == awuh_pkg::ST_RC_START),
      .run((state == awuh_pkg::ST_COUNT) && !wake_flag),
      .tick(rc_tick),
      .presc(wake_prescaler_value),
      .expired(expired)
   );

   // ---------------------------------------------------------------
   // Clock and CPU controls, registered from the next state; rc_capture_clk, int_mask_clear and watchdog_reset_req from the current state
   // ---------------------------------------------------------------
   wire next_awu = (next_state == awuh_pkg::ST_RC_START) || (next_state == awuh_pkg::ST_COUNT);
   wire next_run = (next_state == awuh_pkg::ST_RUN);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         main_osc_enable <= 1'b1;
         periph_clk_enable <= 1'b1;
         cpu_hold <= 1'b0;
         auto_wake_halt_mode <= 1'b0;
         rc_osc_enable <= 1'b0;
         rc_capture_clk <= 1'b0;
         int_mask_clear <= 1'b0;
         watchdog_reset_req <= 1'b0;
      end else if (clk_en) begin
         main_osc_enable <= next_run || (next_state == awuh_pkg::ST_STAB);
         periph_clk_enable <= next_run;
         cpu_hold <= !next_run;
         auto_wake_halt_mode <= next_awu;
         rc_osc_enable <= next_awu || (next_run && osc_measure_enable);
         rc_capture_clk <= rc_s && osc_measure_enable && (state == awuh_pkg::ST_RUN);
         int_mask_clear <= halt_enter;
         watchdog_reset_req <= halt_take && wdg_trap;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n || !clk_en);

   sequence s_awu_request;
      halt_take && !wdg_trap && wake_enable;
   endsequence
   sequence s_awu_entered;
      auto_wake_halt_mode && int_mask_clear && !main_osc_enable;
   endsequence

   property p_enter_awu;
      s_awu_request |=> s_awu_entered;
   endproperty
   a_enter_awu: assert property (p_enter_awu) else $error("auto wake halt not entered");

   property p_flag_set;
      expired |=> wake_flag && wake_irq_req;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("wake flag not set on expiry");

   property p_flag_read_clear;
      rd_csr_done && prdata[2] && !expired |=> !wake_flag;
   endproperty
   a_flag_read_clear: assert property (p_flag_read_clear) else $error("flag kept after read");

   property p_flag_write_ignored;
      wr_ok && hit_csr && !flag_clear && !expired |=> wake_flag == $past(wake_flag);
   endproperty
   a_flag_write_ignored: assert property (p_flag_write_ignored) else $error("flag write took effect");

   property p_presc_zero;
      wr_ok && hit_presc && pwdata[7:0] == 8'h00 |=> $stable(wake_prescaler_value);
   endproperty
   a_presc_zero: assert property (p_presc_zero) else $error("prescaler took zero");

   property p_csr_reserved;
      apb_done && !pwrite && hit_csr |-> prdata[31:3] == 29'h0000_0000;
   endproperty
   a_csr_reserved: assert property (p_csr_reserved) else $error("reserved csr bits set");

   property p_wdg_reset;
      halt_take && wdg_trap |=> watchdog_reset_req && !cpu_hold;
   endproperty
   a_wdg_reset: assert property (p_wdg_reset) else $error("watchdog halt trap missed");

   // Plain delays stand in for a long repetition the tools would unroll
   property p_stab_short;
      $rose(state == awuh_pkg::ST_STAB) && !stab_long_sel
         |-> ##255 state == awuh_pkg::ST_STAB ##1 state == awuh_pkg::ST_RUN;
   endproperty
   a_stab_short: assert property (p_stab_short) else $error("short stabilisation wrong");

   property p_halt_clocks_off;
      in_halt |-> !main_osc_enable && !periph_clk_enable && cpu_hold;
   endproperty
   a_halt_clocks_off: assert property (p_halt_clocks_off) else $error("clock runs in halt");

   property p_exit_irq;
      in_halt && halt_exit_irq |=> state == awuh_pkg::ST_STAB && main_osc_enable;
   endproperty
   a_exit_irq: assert property (p_exit_irq) else $error("halt exit interrupt ignored");
endmodule

// *** testbench/awuh_rc_model.sv ***
// Behavioural model of the RC wake oscillator beside the timer.
// Assumes osc_enable is a level from the block; delays are in ns.
module awuh_rc_model #(
   parameter int HALF_NS = 150,
   parameter int START_NS = 1000
) (
   output logic rc_clk,
   output logic osc_ready,
   input wire logic osc_enable
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Oscillator
   // ---------------------------------------------------------------
   // Start-up time first, then free running; still and low when off
   initial begin
      rc_clk = 1'h0;
      osc_ready = 1'h0;
      forever begin
         wait (osc_enable === 1'h1);
         #START_NS;
         osc_ready = osc_enable;
         while (osc_enable === 1'h1) begin
            #HALF_NS;
            rc_clk = ~rc_clk;
         end
         rc_clk = 1'h0;
         osc_ready = 1'h0;
      end
   end
endmodule

// *** testbench/tb_auto_wakeup_from_halt_timer.sv ***
// Testbench of the wake timer: APB register checks and halt sequences.
// Assumes awuh_rc_model stands in for the RC oscillator.
module tb_auto_wakeup_from_halt_timer;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'h0;
   logic arst_n = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic halt_instr = 1'h0, watchdog_enabled = 1'h0, watchdog_halt_option = 1'h0;
   logic stab_long_sel = 1'h0, halt_exit_irq = 1'h0, clk_en = 1'h1;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rc_clk, rc_osc_ready, rc_osc_enable, rc_capture_clk;
   logic main_osc_enable, periph_clk_enable, cpu_hold, int_mask_clear;
   logic wake_irq_req, watchdog_reset_req, auto_wake_halt_mode, irq;
   logic [4:0] mon;
   int num_errors = 0;
   int total_checks = 0;
   int n;

   // Watched outputs, indexed by the bounded wait
   assign mon = {rc_osc_enable, irq, rc_capture_clk, cpu_hold, wake_irq_req};
   // 20 MHz clock
   always #25 sys_clk = ~sys_clk;

   awuh_top DUT (.sys_clk, .arst_n, .clk_en, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .halt_instr, .watchdog_enabled,
      .watchdog_halt_option, .stab_long_sel, .halt_exit_irq, .rc_clk, .rc_osc_ready,
      .rc_osc_enable, .rc_capture_clk, .main_osc_enable, .periph_clk_enable, .cpu_hold,
      .int_mask_clear, .wake_irq_req, .watchdog_reset_req, .auto_wake_halt_mode, .irq);

   awuh_rc_model rc (.rc_clk(rc_clk), .osc_ready(rc_osc_ready), .osc_enable(rc_osc_enable));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; holds everything until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'h1 && k < 16);
      rdat = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      if (k >= 16) begin
         num_errors++;
         $display("BAD pready timeout");
         give_verdict();
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0000_0000);
      chk($sformatf("read %h", a), e, rdat);
   endtask

   task automatic halt();
      @(posedge sys_clk);
      halt_instr <= 1'h1;
      @(posedge sys_clk);
      halt_instr <= 1'h0;
      @(negedge sys_clk);
   endtask

   // Bounded wait on a watched output; n counts the cycles waited
   task automatic wait_bit(input int i, input logic v, input int lim);
      n = 0;
      while (mon[i] !== v && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= lim) begin
         num_errors++;
         $display("BAD wait on output %0d", i);
         give_verdict();
      end
   endtask

   // External interrupt ends a halt; stabilisation is then counted
   task automatic leave_halt(input int cyc);
      @(posedge sys_clk);
      halt_exit_irq <= 1'h1;
      @(posedge sys_clk);
      halt_exit_irq <= 1'h0;
      @(negedge sys_clk);
      wait_bit(1, 1'h0, 5000);
      chk("stab cycles", cyc, n);
   endtask

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   // Hang guard: stays well above the longest legal run
   initial begin
      repeat (100000) @(posedge sys_clk);
      num_errors++;
      $display("BAD run timeout");
      give_verdict();
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'h1;
      rd(awuh_pkg::PRESC_ADDR, 32'h0000_00FF);
      rd(awuh_pkg::CSR_ADDR, 32'h0000_0000);
      rd(awuh_pkg::IRQ_STATUS_ADDR, 32'h0000_0000);
      rd(awuh_pkg::IRQ_MASK_ADDR, 32'h0000_0000);
      rd(12'h200, 32'h0000_0000);
      chk("pslverr", 32'h0000_0001, pslverr);
      apb(1'h1, awuh_pkg::PRESC_ADDR, 32'h0000_0000);
      rd(awuh_pkg::PRESC_ADDR, 32'h0000_00FF);
      apb(1'h1, awuh_pkg::PRESC_ADDR, 32'h0000_0002);
      rd(awuh_pkg::PRESC_ADDR, 32'h0000_0002);
      apb(1'h1, awuh_pkg::CSR_ADDR, 32'hFFFF_FFFF);
      rd(awuh_pkg::CSR_ADDR, 32'h0000_0003);
      $display("register test done");
      wait_bit(2, 1'h1, 200);
      chk("rc enable", 32'h0000_0001, rc_osc_enable);
      apb(1'h1, awuh_pkg::CSR_ADDR, 32'h0000_0001);
      wait_bit(4, 1'h0, 5);
      $display("measure test done");
      // Wake halt cut short by another interrupt partway through the count
      apb(1'h1, awuh_pkg::IRQ_MASK_ADDR, 32'h0000_0003);
      halt();
      chk("halt mode", 32'h0000_0001, auto_wake_halt_mode);
      chk("mask clear", 32'h0000_0001, int_mask_clear);
      chk("main osc", 32'h0000_0000, main_osc_enable);
      chk("periph clk", 32'h0000_0000, periph_clk_enable);
      repeat (300) @(posedge sys_clk);
      leave_halt(256);
      chk("wake req", 32'h0000_0000, wake_irq_req);
      rd(awuh_pkg::IRQ_STATUS_ADDR, 32'h0000_0002);
      chk("irq", 32'h0000_0001, irq);
      apb(1'h1, awuh_pkg::IRQ_STATUS_ADDR, 32'h0000_0002);
      rd(awuh_pkg::IRQ_STATUS_ADDR, 32'h0000_0000);
      chk("irq", 32'h0000_0000, irq);
      $display("interrupted halt test done");
      // Full wake: the count must start again from zero
      halt();
      wait_bit(0, 1'h1, 2000);
      chk("wake delay", 32'h0000_0001, 32'(n >= 768 && n <= 820));
      chk("main osc", 32'h0000_0001, main_osc_enable);
      chk("halt mode", 32'h0000_0000, auto_wake_halt_mode);
      wait_bit(1, 1'h0, 5000);
      chk("stab cycles", 32'h0000_0100, n);
      chk("irq", 32'h0000_0001, irq);
      rd(awuh_pkg::CSR_ADDR, 32'h0000_0005);
      rd(awuh_pkg::CSR_ADDR, 32'h0000_0001);
      chk("wake req", 32'h0000_0000, wake_irq_req);
      apb(1'h1, awuh_pkg::IRQ_STATUS_ADDR, 32'h0000_0001);
      $display("wake test done");
      // Frozen enable must swallow a halt pulse although the trap is armed
      watchdog_enabled <= 1'h1;
      clk_en <= 1'h0;
      halt();
      chk("frozen wdg", 32'h0000_0000, watchdog_reset_req);
      @(posedge sys_clk);
      clk_en <= 1'h1;
      // Watchdog trap, then plain halt with the long stabilisation
      watchdog_enabled <= 1'h1;
      halt();
      chk("wdg reset", 32'h0000_0001, watchdog_reset_req);
      chk("cpu hold", 32'h0000_0000, cpu_hold);
      @(posedge sys_clk);
      watchdog_halt_option <= 1'h1;
      stab_long_sel <= 1'h1;
      apb(1'h1, awuh_pkg::CSR_ADDR, 32'h0000_0000);
      halt();
      chk("cpu hold", 32'h0000_0001, cpu_hold);
      chk("halt mode", 32'h0000_0000, auto_wake_halt_mode);
      leave_halt(4096);
      $display("watchdog and plain halt test done");
      give_verdict();
   end
endmodule
